// [verilog/gate_sync_pulse_sequencer.sv]
// Purpose: trigger-driven sync, aux and gate pulse sequencer with a
//          classic Wishbone register file
// Assumes: trigIn synchronous to clk; all times in clock cycles
// Notes:   pulses that overlap the next trigger are restarted by it
`timescale 1ns/10ps
`include "gsps_defs.svh"

// How it works
// R01 - enabled primary sync follows trigger rate
// R02 - secondary sync copies primary shape and width
// R03 - secondary edges lag primary by programmed delay
// R04 - aux pulse width equals programmed width
// R05 - aux starts programmed delay after primary
// R06 - gate mode: cathode on only during gate
// R07 - first acquisition start width, last end width
// R08 - first acquisition start delay, last end delay
// R09 - equal start/end widths keep width constant
// R10 - programmed gate count per exposure, then readout
// R11 - master clock: internal trigger drives sync
// R12 - fixed increments step width and delay linearly
module gate_sync_pulse_sequencer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        trigIn,
  output wire logic        primarySyncOutput,
  output wire logic        secondarySyncOutput,
  output wire logic        auxOut,
  output wire logic        gateOut,
  output wire logic        cathodeOn,
  output logic             exposureEnd,
  output wire logic        seqBusy
);
  import gsps_pkg::*;

  // ---------------- register file ----------------
  logic [31:0] cfg [`GSPS_NCFG];  // writable configuration words

  wire logic       wbReq  = wb_cyc_i & wb_stb_i;
  wire logic [3:0] idx    = wb_adr_i[`GSPS_IDX_MSB:`GSPS_IDX_LSB];
  wire logic       inMap  = (wb_adr_i[`GSPS_ADR_MSB:`GSPS_ADR_TOP] == '0);
  wire logic       isCfg  = inMap & (idx < `GSPS_IDX_STATUS);
  // writes land on the edge where the master sees ack
  wire logic       wrEn   = wb_ack_o & wb_we_i & isCfg;
  wire logic [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // named views of the configuration
  wire logic        syncEn   = cfg[`GSPS_IDX_CTRL][`GSPS_CTRL_SYNC_EN];
  wire logic        intTrig  = cfg[`GSPS_IDX_CTRL][`GSPS_CTRL_INT_TRIG];
  wire logic        gateMode = cfg[`GSPS_IDX_CTRL][`GSPS_CTRL_GATE_MD];
  wire logic [31:0] period   = cfg[`GSPS_IDX_PERIOD];
  wire logic [31:0] syncW    = cfg[`GSPS_IDX_SYNC_W];
  wire logic [31:0] sync2D   = cfg[`GSPS_IDX_SYNC2_D];
  wire logic [31:0] auxW     = cfg[`GSPS_IDX_AUX_W];
  wire logic [31:0] auxD     = cfg[`GSPS_IDX_AUX_D];
  wire logic [31:0] wStart   = cfg[`GSPS_IDX_W_START];
  wire logic [31:0] wEnd     = cfg[`GSPS_IDX_W_END];
  wire logic [31:0] dStart   = cfg[`GSPS_IDX_D_START];
  wire logic [31:0] dEnd     = cfg[`GSPS_IDX_D_END];
  wire logic [31:0] wInc     = cfg[`GSPS_IDX_W_INC];
  wire logic [31:0] dInc     = cfg[`GSPS_IDX_D_INC];
  wire logic [31:0] nAcq     = cfg[`GSPS_IDX_N_ACQ];
  wire logic [31:0] gates    = cfg[`GSPS_IDX_GATES];

  // start is a write strobe, not a stored level that re-arms
  wire logic startPulse = wrEn & (idx == `GSPS_IDX_CTRL) & wb_sel_i[0]
                        & wb_dat_i[`GSPS_CTRL_START];

  // one short process per configuration word, byte lanes by sel
  for (genvar r = 0; r < `GSPS_NCFG; r++) begin : g_cfg
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cfg[r] <= `GSPS_ZERO;
      end else if (wrEn && idx == 4'(r)) begin
        cfg[r] <= (cfg[r] & ~laneMask) | (wb_dat_i & laneMask);
      end
    end
  end

  // ---------------- sequencer state ----------------
  seq_state_t  seq;      // idle or running a sequence
  logic [31:0] curW;     // gate width for this acquisition
  logic [31:0] curD;     // gate delay for this acquisition
  logic [31:0] acqIdx;   // acquisition number within sequence
  logic [31:0] gateCnt;  // gates issued in this exposure

  assign seqBusy = (seq == S_RUN);

  wire logic [31:0] status = {acqIdx[`GSPS_ST_ACQ_W-1:0],
                              gateCnt[`GSPS_ST_GATE_W-1:0], seqBusy};

  // read select; unmapped words answer zero
  wire logic [31:0] rdMux = isCfg ? cfg[idx] :
                            (inMap && idx == `GSPS_IDX_STATUS) ? status :
                            `GSPS_ZERO;

  // one wait state: ack a cycle after the request, drop it after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `GSPS_ZERO;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      if (wbReq && !wb_ack_o) begin
        wb_dat_o <= rdMux;
      end
    end
  end

  // ---------------- trigger source ----------------
  logic        trigPrev;  // last sample of external trigger
  logic [31:0] rateCnt;   // internal rate divider

  wire logic extEdge  = trigIn & ~trigPrev;
  wire logic rateLast = ((rateCnt + `GSPS_ONE) >= period);
  // zero period stops the internal source rather than run flat out
  wire logic intTick  = intTrig & (period != `GSPS_ZERO)
                      & (rateCnt == `GSPS_ZERO);
  wire logic trig     = intTrig ? intTick : extEdge;  // R11

  // edge capture and rate divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev <= 1'b0;
      rateCnt  <= `GSPS_ZERO;
    end else begin
      trigPrev <= trigIn;
      rateCnt  <= (!intTrig || rateLast) ? `GSPS_ZERO
                                         : rateCnt + `GSPS_ONE;
    end
  end

  // ---------------- pulse timers ----------------
  pulse_if p1 ();  // primary sync
  pulse_if p2 ();  // secondary sync
  pulse_if pa ();  // auxiliary trigger
  pulse_if pg ();  // photocathode gate

  // every sync-family pulse launches on the same trigger
  wire logic syncStart = trig & syncEn;  // R01
  wire logic gateFire  = trig & seqBusy;

  assign p1.start = syncStart;
  assign p1.delay = `GSPS_ZERO;
  assign p1.width = syncW;
  // same width, only the launch delay differs
  assign p2.start = syncStart;  // R02
  assign p2.delay = sync2D;     // R03
  assign p2.width = syncW;      // R02
  assign pa.start = syncStart;  // R05
  assign pa.delay = auxD;       // R05
  assign pa.width = auxW;       // R04
  assign pg.start = gateFire;
  assign pg.delay = curD;
  assign pg.width = curW;

  pulse_timer u_p1 (.clk(clk), .rst(rst), .pt(p1));
  pulse_timer u_p2 (.clk(clk), .rst(rst), .pt(p2));
  pulse_timer u_pa (.clk(clk), .rst(rst), .pt(pa));
  pulse_timer u_pg (.clk(clk), .rst(rst), .pt(pg));

  assign primarySyncOutput   = p1.out;
  assign secondarySyncOutput = p2.out;
  assign auxOut              = pa.out;
  assign gateOut             = pg.out;
  // safe mode keeps the cathode off even while gates run
  assign cathodeOn           = pg.out & gateMode;  // R06

  // ---------------- acquisition stepping ----------------
  wire logic lastGate = ((gateCnt + `GSPS_ONE) >= gates);  // R10
  wire logic lastAcq  = ((acqIdx + `GSPS_ONE) >= nAcq);
  wire logic nextLast = ((acqIdx + `GSPS_TWO) >= nAcq);

  // end values land exactly, never by accumulated steps
  wire logic [31:0] next_width = nextLast ? wEnd :          // R07
                                 (wStart == wEnd) ? curW :  // R09
                                 curW + wInc;               // R12
  wire logic [31:0] next_delay = nextLast ? dEnd :          // R08
                                 curD + dInc;               // R12

  // sequence control; a fresh start aborts a running sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq         <= S_IDLE;
      curW        <= `GSPS_ZERO;
      curD        <= `GSPS_ZERO;
      acqIdx      <= `GSPS_ZERO;
      gateCnt     <= `GSPS_ZERO;
      exposureEnd <= 1'b0;
    end else begin
      exposureEnd <= 1'b0;
      if (startPulse) begin
        seq     <= S_RUN;
        acqIdx  <= `GSPS_ZERO;
        gateCnt <= `GSPS_ZERO;
        curW    <= wStart;  // R07
        curD    <= dStart;  // R08
      end else begin
        unique case (seq)
          S_IDLE: seq <= S_IDLE;
          S_RUN: begin
            if (trig && !lastGate) begin
              gateCnt <= gateCnt + `GSPS_ONE;  // R10
            end else if (trig) begin
              gateCnt     <= `GSPS_ZERO;
              exposureEnd <= 1'b1;              // R10
              acqIdx      <= acqIdx + `GSPS_ONE;
              if (lastAcq) begin
                seq <= S_IDLE;
              end else begin
                curW <= next_width;
                curD <= next_delay;
              end
            end
          end
        endcase
      end
    end
  end

  // ---------------- checks ----------------
  logic        p1Prev;  // primary level one cycle back
  logic [31:0] len2;    // secondary high run length
  logic [31:0] lenA;    // aux high run length
  logic [31:0] sinceP;  // cycles since primary leading edge

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p1Prev <= 1'b0;
      len2   <= `GSPS_ZERO;
      lenA   <= `GSPS_ZERO;
      sinceP <= `GSPS_ZERO;
    end else begin
      p1Prev <= primarySyncOutput;
      len2   <= secondarySyncOutput ? len2 + `GSPS_ONE : `GSPS_ZERO;
      lenA   <= auxOut ? lenA + `GSPS_ONE : `GSPS_ZERO;
      sinceP <= (primarySyncOutput && !p1Prev) ? `GSPS_ONE
                                               : sinceP + `GSPS_ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sync_follows;
    syncStart && syncW != `GSPS_ZERO |=> primarySyncOutput;
  endproperty
  a_sync_follows: assert property (p_sync_follows) // R01
    else $error("primary sync missed a trigger");

  property p_sec_width;
    $fell(secondarySyncOutput) |-> len2 == syncW;
  endproperty
  a_sec_width: assert property (p_sec_width) // R02
    else $error("secondary sync width differs from primary");

  property p_sec_delay;
    $rose(secondarySyncOutput) && sync2D != `GSPS_ZERO
      |-> sinceP == sync2D;
  endproperty
  a_sec_delay: assert property (p_sec_delay) // R03
    else $error("secondary sync delay wrong");

  property p_aux_width;
    $fell(auxOut) |-> lenA == auxW;
  endproperty
  a_aux_width: assert property (p_aux_width) // R04
    else $error("aux pulse width wrong");

  property p_aux_delay;
    $rose(auxOut) && auxD != `GSPS_ZERO |-> sinceP == auxD;
  endproperty
  a_aux_delay: assert property (p_aux_delay) // R05
    else $error("aux pulse delay wrong");

  property p_cathode;
    cathodeOn |-> gateOut && gateMode;
  endproperty
  a_cathode: assert property (p_cathode) // R06
    else $error("cathode on outside a gate");

  property p_first_vals;
    startPulse |=> curW == $past(wStart) && curD == $past(dStart);
  endproperty
  a_first_vals: assert property (p_first_vals) // R07
    else $error("first acquisition not at start values");

  property p_last_vals;
    seqBusy && trig && lastGate && !lastAcq && nextLast && !startPulse
      |=> curW == $past(wEnd) && curD == $past(dEnd);
  endproperty
  a_last_vals: assert property (p_last_vals) // R08
    else $error("last acquisition not at end values");

  property p_const_width;
    seqBusy && wStart == wEnd && curW == wStart && !startPulse
      |=> curW == $past(curW);
  endproperty
  a_const_width: assert property (p_const_width) // R09
    else $error("gate width moved with equal start and end");

  property p_exposure;
    seqBusy && trig && lastGate && !startPulse
      |=> exposureEnd && gateCnt == `GSPS_ZERO
      ##1 (!exposureEnd || $past(trig));
  endproperty
  a_exposure: assert property (p_exposure) // R10
    else $error("exposure did not close after last gate");

  property p_master;
    intTrig && syncEn && intTick && syncW != `GSPS_ZERO
      |=> primarySyncOutput;
  endproperty
  a_master: assert property (p_master) // R11
    else $error("internal tick did not drive primary sync");

  property p_step;
    seqBusy && trig && lastGate && !nextLast && !startPulse
      |=> curD == $past(curD) + $past(dInc);
  endproperty
  a_step: assert property (p_step) // R12
    else $error("gate delay did not step by increment");

  c_seq_done: cover property (exposureEnd && !seqBusy);
  c_sec_pulse: cover property ($fell(secondarySyncOutput));
  c_aux_pulse: cover property ($fell(auxOut));
  c_cathode: cover property ($rose(cathodeOn));
endmodule

// [verilog/gsps_defs.svh]
// Purpose: register map, field positions and constants of the gate
//          and sync pulse sequencer
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes:   all times are counts of 20 ns clock cycles
`ifndef GSPS_DEFS_SVH
`define GSPS_DEFS_SVH

// register word indices (byte address = index * 4)
`define GSPS_IDX_CTRL      4'h0
`define GSPS_IDX_PERIOD    4'h1
`define GSPS_IDX_SYNC_W    4'h2
`define GSPS_IDX_SYNC2_D   4'h3
`define GSPS_IDX_AUX_W     4'h4
`define GSPS_IDX_AUX_D     4'h5
`define GSPS_IDX_W_START   4'h6
`define GSPS_IDX_W_END     4'h7
`define GSPS_IDX_D_START   4'h8
`define GSPS_IDX_D_END     4'h9
`define GSPS_IDX_W_INC     4'hA
`define GSPS_IDX_D_INC     4'hB
`define GSPS_IDX_N_ACQ     4'hC
`define GSPS_IDX_GATES     4'hD
`define GSPS_IDX_STATUS    4'hE
`define GSPS_NCFG          14

// address decode
`define GSPS_IDX_LSB       2
`define GSPS_IDX_MSB       5
`define GSPS_ADR_TOP       6
`define GSPS_ADR_MSB       31

// control bits
`define GSPS_CTRL_SYNC_EN  0
`define GSPS_CTRL_INT_TRIG 1
`define GSPS_CTRL_GATE_MD  2
`define GSPS_CTRL_START    3

// status field widths: {acq index, gate count, busy}
`define GSPS_ST_ACQ_W      16
`define GSPS_ST_GATE_W     15

// word constants
`define GSPS_ZERO          32'h0000_0000
`define GSPS_ONE           32'h0000_0001
`define GSPS_TWO           32'h0000_0002

`endif

// [verilog/gsps_pkg.sv]
// Purpose: shared types of the gate and sync pulse sequencer
// Assumes: nothing
// Notes:   numbers live in gsps_defs.svh
package gsps_pkg;
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_HIGH} timer_state_t;
  typedef enum logic {S_IDLE, S_RUN} seq_state_t;
endpackage

// [verilog/pulse_if.sv]
// Purpose: request bundle between the sequencer and a pulse timer
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse
`timescale 1ns/10ps
interface pulse_if;
  logic        start;  // launch one pulse
  logic [31:0] delay;  // cycles from start to leading edge
  logic [31:0] width;  // cycles high
  logic        out;    // pulse level

  modport timer (input start, input delay, input width, output out);
  modport ctl   (output start, output delay, output width, input out);
endinterface

// [verilog/pulse_timer.sv]
// Purpose: delay-then-width one-shot pulse generator
// Assumes: start is synchronous to clk
// Notes:   a new start restarts the timer, cutting any pulse in flight
`timescale 1ns/10ps
`include "gsps_defs.svh"
module pulse_timer (
  input wire logic clk,
  input wire logic rst,
  pulse_if.timer   pt
);
  import gsps_pkg::*;

  timer_state_t state;   // idle, counting delay, driving high
  logic [31:0]  cnt;     // remaining cycles in this phase
  logic [31:0]  widthLt; // width caught at start, so edits mid-pulse
                         // cannot change the shape already launched

  wire logic lastCnt = (cnt == `GSPS_ONE);
  wire logic noDelay = (pt.delay == `GSPS_ZERO);
  wire logic noWidth = (pt.width == `GSPS_ZERO);

  // output is a decode of the state flop only
  assign pt.out = (state == T_HIGH);

  // phase sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= T_IDLE;
      cnt     <= `GSPS_ZERO;
      widthLt <= `GSPS_ZERO;
    end else if (pt.start) begin
      widthLt <= pt.width;
      if (noWidth) begin
        state <= T_IDLE;          // zero width: no pulse at all
      end else if (noDelay) begin
        state <= T_HIGH;
        cnt   <= pt.width;
      end else begin
        state <= T_WAIT;
        cnt   <= pt.delay;
      end
    end else begin
      unique case (state)
        T_IDLE: state <= T_IDLE;
        T_WAIT: begin
          if (lastCnt) begin
            state <= T_HIGH;
            cnt   <= widthLt;
          end else begin
            cnt <= cnt - `GSPS_ONE;
          end
        end
        T_HIGH: begin
          if (lastCnt) begin
            state <= T_IDLE;
          end else begin
            cnt <= cnt - `GSPS_ONE;
          end
        end
      endcase
    end
  end
endmodule

// [tb/light_source_model.sv]
// Purpose: pulsed light source fired by the primary sync output
// Assumes: one event per rising edge of its trigger input
// Notes:   flash length is a plain parameter
`timescale 1ns/10ps
module light_source_model #(
  parameter int FLASH_W = 2  // cycles of light per event
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fireIn,
  output int        fireCount,
  output logic      flash
);
  logic lastIn;  // previous trigger level
  int   left;    // flash cycles still due

  // fire once per rising edge; a level held high fires only once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastIn    <= 1'b0;
      fireCount <= 0;
      left      <= 0;
    end else begin
      lastIn <= fireIn;
      if (fireIn && !lastIn) begin
        fireCount <= fireCount + 1;
        left      <= FLASH_W;
      end else if (left > 0) begin
        left <= left - 1;
      end
    end
  end

  assign flash = (left > 0);  // light only while an event burns
endmodule

// [tb/test_gate_sync_pulse_sequencer.sv]
// Purpose: self-checking bench of the gate and sync pulse sequencer
// Assumes: 50 MHz clock, all times in clock cycles
// Notes:   edge times come from a cycle counter sampled at rising edges
`timescale 1ns/10ps
`include "gsps_defs.svh"
module test_gate_sync_pulse_sequencer;
  logic        clk, rst;       // clock, async reset
  logic        cyc, stb, we;   // bus request
  logic [31:0] adr, datI;      // bus address, write data
  logic [3:0]  sel;            // byte lanes
  wire  [31:0] datO;           // read data
  wire         ack;            // bus answer
  logic        trigIn;         // external trigger
  wire         pri, sec, aux, gate, cat, expEnd, busy;
  wire         flash;          // light source output, counted
  int          fires;          // events fired by the light source
  int          errTotal, checkCount;
  int          cy, cc, bad, ne, fl;  // cycles, cathode, stray, exp, flash
  int          rt[4], ft[4], pr[4], nr[4];  // rise, fall, prior, count
  logic [3:0]  prev;           // last sampled pulse levels
  wire  [3:0]  sig = {gate, aux, sec, pri};

  gate_sync_pulse_sequencer dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .trigIn(trigIn),
    .primarySyncOutput(pri), .secondarySyncOutput(sec), .auxOut(aux),
    .gateOut(gate), .cathodeOn(cat), .exposureEnd(expEnd),
    .seqBusy(busy));

  light_source_model ls (.clk(clk), .rst(rst), .fireIn(pri),
    .fireCount(fires), .flash(flash));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // edge recorder; reads the levels from before this edge's updates
  always @(posedge clk) begin
    cy++;
    for (int k = 0; k < 4; k++) begin
      if (sig[k] === 1'b1 && prev[k] !== 1'b1) begin
        pr[k] = rt[k];
        rt[k] = cy;
        nr[k]++;
      end
      if (sig[k] !== 1'b1 && prev[k] === 1'b1) begin
        ft[k] = cy;
      end
    end
    prev = sig;
    if (cat === 1'b1) begin
      cc++;
    end
    if (cat === 1'b1 && gate !== 1'b1) begin  // cathode without gate
      bad++;
    end
    if (expEnd === 1'b1) begin
      ne++;
    end
    if (flash === 1'b1) begin
      fl++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one classic cycle; called just after a rising edge
  task automatic wb(input logic w, input logic [31:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    datI <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin  // slave never answered
      errTotal++;
      tallyAndFinish();
    end
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);  // bus idle one cycle between requests
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, {26'h0, i, 2'h0}, d, 4'hF, q);
  endtask

  task automatic rd(input logic [3:0] i, output logic [31:0] q);
    wb(1'b0, {26'h0, i, 2'h0}, 32'h0, 4'hF, q);
  endtask

  // one trigger edge, then room for every pulse to finish
  task automatic trig;
    for (int k = 0; k < 4; k++) begin  // stale edges must not match
      rt[k] = -100 * (k + 1);
      ft[k] = 0;
    end
    trigIn <= 1'b1;
    repeat (2) @(posedge clk);
    trigIn <= 1'b0;
    repeat (40) @(posedge clk);
  endtask

  task automatic testRegs;
    logic [31:0] q;
    rd(`GSPS_IDX_PERIOD, q);
    chk(q, 32'h0);
    wb(1'b1, 32'h0000_0004, 32'hAABB_CCDD, 4'h3, q);  // low lanes only
    rd(`GSPS_IDX_PERIOD, q);
    chk(q, 32'h0000_CCDD);
    wb(1'b1, 32'h0000_0044, 32'h1234_5678, 4'hF, q);  // unmapped alias
    rd(`GSPS_IDX_PERIOD, q);
    chk(q, 32'h0000_CCDD);
    wr(`GSPS_IDX_STATUS, 32'hFFFF_FFFF);  // read-only place
    rd(`GSPS_IDX_STATUS, q);
    chk(q, 32'h0);
    rd(4'hF, q);
    chk(q, 32'h0);
    wr(`GSPS_IDX_PERIOD, 32'h0);
    $display("test regs done");
  endtask

  task automatic testPulse;
    int ad[2] = '{0, 6};  // aux delay: boundary zero and nonzero
    int n0;
    wr(`GSPS_IDX_SYNC_W, 32'h5);
    wr(`GSPS_IDX_SYNC2_D, 32'h7);
    wr(`GSPS_IDX_AUX_W, 32'h3);
    wr(`GSPS_IDX_CTRL, 32'h1);
    foreach (ad[k]) begin
      wr(`GSPS_IDX_AUX_D, ad[k]);
      trig();
      chk(ft[0] - rt[0], 5);
      chk(ft[1] - rt[1], 5);
      chk(rt[1] - rt[0], 7);
      chk(ft[1] - ft[0], 7);
      chk(ft[2] - rt[2], 3);
      chk(rt[2] - rt[0], ad[k]);
    end
    n0 = nr[0] + nr[1] + nr[2];
    wr(`GSPS_IDX_CTRL, 32'h0);  // sync disabled: trigger gives nothing
    trig();
    chk(nr[0] + nr[1] + nr[2], n0);
    $display("test pulse done");
  endtask

  task automatic testMaster;
    int f0, n0, l0;
    f0 = fires;
    l0 = fl;
    n0 = nr[0];
    wr(`GSPS_IDX_PERIOD, 32'h14);
    wr(`GSPS_IDX_CTRL, 32'h3);  // internal trigger, sync on
    repeat (100) @(posedge clk);
    chk(rt[0] - pr[0], 20);
    wr(`GSPS_IDX_CTRL, 32'h0);
    wr(`GSPS_IDX_PERIOD, 32'h0);
    repeat (30) @(posedge clk);
    chk(nr[0] - n0 >= 4, 1'b1);
    chk(fires - f0, nr[0] - n0);
    chk(fl - l0, 2 * (fires - f0));
    $display("test master done");
  endtask

  // program a sweep, trigger every gate, judge each one
  task automatic runSeq(input int ws, we2, wi, ds, de, di, n, g, gm);
    int w, d, e0, c0;
    logic [31:0] q;
    wr(`GSPS_IDX_W_START, ws);
    wr(`GSPS_IDX_W_END, we2);
    wr(`GSPS_IDX_W_INC, wi);
    wr(`GSPS_IDX_D_START, ds);
    wr(`GSPS_IDX_D_END, de);
    wr(`GSPS_IDX_D_INC, di);
    wr(`GSPS_IDX_N_ACQ, n);
    wr(`GSPS_IDX_GATES, g);
    e0 = ne;
    wr(`GSPS_IDX_CTRL, 32'h9 | (gm << 2));  // start, sync on
    chk(busy, 1'b1);
    rd(`GSPS_IDX_STATUS, q);
    chk(q, 32'h1);
    for (int a = 0; a < n; a++) begin
      if (a == 0) begin
        w = ws;
        d = ds;
      end else if (a == n - 1) begin
        w = we2;
        d = de;
      end else begin
        w = (ws == we2) ? w : w + wi;
        d = d + di;
      end
      for (int k = 0; k < g; k++) begin
        c0 = cc;
        trig();
        chk(ft[3] - rt[3], w);
        chk(rt[3] - rt[0], d);
        chk(cc - c0, gm ? w : 0);
        if (k == 0 && g > 1) begin  // part-way through an exposure
          rd(`GSPS_IDX_STATUS, q);
          chk(q, (a << 16) | 32'h3);
        end
      end
      chk(ne - e0, a + 1);
    end
    chk(busy, 1'b0);
    rd(`GSPS_IDX_STATUS, q);
    chk(q, n << 16);
    chk(bad, 0);
    $display("test sequence done");
  endtask

  // main sequence
  initial begin
    rst    = 1'b1;
    cyc    = 1'b0;
    stb    = 1'b0;
    we     = 1'b0;
    adr    = 32'h0;
    datI   = 32'h0;
    sel    = 4'h0;
    trigIn = 1'b0;
    prev   = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testRegs();
    testPulse();
    testMaster();
    runSeq(4, 4, 1, 2, 8, 3, 3, 2, 1);  // fixed width, delay sweep
    runSeq(3, 9, 3, 1, 1, 0, 3, 1, 0);  // width sweep, cathode off
    tallyAndFinish();
  end
endmodule
